// ==== logic/input_path_control.sv ====
// converter input path control with axi4-lite registers
//
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: positive input selects any of ten pins or the supply rail.
// R2: negative input selects any of ten pins or the ground rail.
// R3: inputs zero and one feed reference pair zero when chosen.
// R4: each current source routes to any one of ten pins.
// R5: bias voltage routes only to inputs zero to seven.
// R6: excitation current level has sixteen settings.
// R7: auxiliary sink and source switch on for broken-wire detection.
// R8: one field selects bypass, buffered or amplifier path.
// R9: bypass disables buffers and amplifier.
// R10: buffered enables buffers, amplifier off.
// R11: amplifier mode enables amplifier, buffers off.
// R12: amplifier gains one to one hundred twenty-eight, doubling.
// R13: bypass and buffered offer digital gain two and four.
// R14: digital gain four or more is four; result cut 32 to 24 bits.
// R15: external clock select takes the conversion clock from pin zero.
// R16: continuous up to 1920 sps, single-cycle up to 480 sps.
// R17: single-cycle settles in one cycle; fir result within 16 ms.
// R18: host supplies serial clock for each command; here commands arrive over AXI4-Lite, clocked by aclk.
// R19: path, mux and gain changes apply at next conversion start.
module input_path_control
  import input_path_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic general_pin_zero_clock_in,
  output logic [10:0] pos_input_sel_q,
  output logic [10:0] neg_input_sel_q,
  output logic reference_zero_en_q,
  output logic [9:0] excitation_current_source_zero_route_q,
  output logic [9:0] excitation_current_source_one_route_q,
  output logic [3:0] excitation_level_q,
  output logic [7:0] bias_voltage_source_route_q,
  output logic wire_sink_en_q,
  output logic wire_source_en_q,
  output logic input_buffer_en_q,
  output logic programmable_gain_amplifier_en_q,
  output logic [2:0] amp_gain_q,
  output logic external_clock_select_q,
  output logic conv_busy_q,
  output logic conv_done_q
);
  // software-visible control registers
  logic [3:0] mux_pos_q, mux_neg_q;
  logic ref0_sel_q;
  logic [3:0] cur0_pin_q, cur1_pin_q, level_q;
  logic cur0_on_q, cur1_on_q;
  logic [7:0] bias_q;
  logic sink_q, source_q;
  logic [1:0] path_q;
  logic [2:0] gain_q;
  logic ext_clk_q, single_q, fir_q, start_q;
  logic [MOD_W-1:0] mod_data_q;
  logic [RES_W-1:0] result_q;
  // settings latched at conversion start
  logic [1:0] act_path_q;
  logic [2:0] act_gain_q;
  logic [3:0] act_pos_q, act_neg_q;
  conv_state_type conv_state_q;
  logic [31:0] conv_cnt_q;
  logic [2:0] ext_sync_q;
  logic ext_rise;
  // axi channel state
  logic aw_held_q, w_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_go;

  function automatic logic [10:0] onehot11(input logic [3:0] code);
    onehot11 = 11'h000;
    if (code <= MUX_RAIL) begin
      onehot11[code] = 1'b1;
    end
  endfunction : onehot11

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // write address/data taken independently, response after both
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_q && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q == OFS_MUX || aw_addr_q == OFS_EXCITE || aw_addr_q == OFS_PATH
                      || aw_addr_q == OFS_CONV || aw_addr_q == OFS_MOD_DATA) ? RESP_OKAY
                      : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; out-of-range codes are refused so illegal routes never appear
  always_ff @(posedge aclk) begin
    logic [31:0] v;
    v = '0;
    if (!aresetn) begin
      mux_pos_q <= '0;
      mux_neg_q <= MUX_RAIL;
      ref0_sel_q <= 1'b0;
      {cur1_pin_q, cur0_pin_q} <= '0;
      {cur1_on_q, cur0_on_q} <= '0;
      level_q <= '0;
      bias_q <= '0;
      {source_q, sink_q} <= '0;
      path_q <= PATH_BYPASS;
      gain_q <= '0;
      {fir_q, single_q, ext_clk_q, start_q} <= '0;
      mod_data_q <= '0;
    end else begin
      start_q <= 1'b0;
      if (wr_go) begin
        unique case (aw_addr_q)
          OFS_MUX: begin
            v = merge({19'h0, ref0_sel_q, 4'h0, mux_neg_q, mux_pos_q}, w_data_q, w_strb_q);
            if (v[3:0] <= MUX_RAIL) mux_pos_q <= v[3:0]; // R1
            if (v[7:4] <= MUX_RAIL) mux_neg_q <= v[7:4]; // R2
            ref0_sel_q <= v[12]; // R3
          end
          OFS_EXCITE: begin
            v = merge({8'h0, source_q, sink_q, bias_q, level_q, cur1_on_q, cur0_on_q,
                       cur1_pin_q, cur0_pin_q}, w_data_q, w_strb_q);
            if (v[3:0] <= IDAC_LAST_PIN) cur0_pin_q <= v[3:0]; // R4
            if (v[7:4] <= IDAC_LAST_PIN) cur1_pin_q <= v[7:4]; // R4
            {cur1_on_q, cur0_on_q} <= v[9:8];
            level_q <= v[13:10]; // R6
            bias_q <= v[21:14]; // R5
            {source_q, sink_q} <= v[23:22]; // R7
          end
          OFS_PATH: begin
            v = merge({27'h0, gain_q, path_q}, w_data_q, w_strb_q);
            if (v[1:0] != 2'b11) path_q <= v[1:0]; // R8
            gain_q <= v[4:2];
          end
          OFS_CONV: begin
            v = merge({29'h0, fir_q, single_q, ext_clk_q}, w_data_q, w_strb_q);
            {fir_q, single_q, ext_clk_q} <= v[2:0]; // R15
            start_q <= v[3];
          end
          OFS_MOD_DATA: mod_data_q <= merge(mod_data_q, w_data_q, w_strb_q);
          default: ;
        endcase
      end
    end
  end

  // external clock pin: three flops, rising edge when the second is high and the third still low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_sync_q <= '0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], general_pin_zero_clock_in};
    end
  end
  assign ext_rise = ext_sync_q[1] && !ext_sync_q[2];

  // conversion sequencer: settings captured only at start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conv_state_q <= CONV_IDLE;
      conv_cnt_q <= '0;
      act_path_q <= PATH_BYPASS;
      {act_gain_q, act_pos_q} <= '0;
      act_neg_q <= MUX_RAIL;
      {conv_done_q, conv_busy_q} <= '0;
      result_q <= '0;
    end else begin
      conv_done_q <= 1'b0;
      unique case (conv_state_q)
        CONV_IDLE: begin
          if (start_q || (!single_q && conv_busy_q)) begin
            conv_state_q <= CONV_RUN; // R19
            act_path_q <= path_q; // R19
            act_gain_q <= gain_q;
            act_pos_q <= mux_pos_q;
            act_neg_q <= mux_neg_q;
            conv_busy_q <= 1'b1;
            // one settled cycle per conversion; fir bounded by its settle time
            // pin counts assume the nominal pin frequency, so a slower pin stretches them
            conv_cnt_q <= ext_clk_q ? (fir_q ? 32'(FIR_EDGES) : single_q ? 32'(SINGLE_EDGES)
                                       : 32'(CONT_EDGES)) // R15
                        : fir_q ? 32'(FIR_CYCLES) // R17
                        : single_q ? 32'(SINGLE_CYCLES) : 32'(CONT_CYCLES); // R16
          end
        end
        CONV_RUN: begin
          // with external clock, the countdown follows the pin so rate scales
          if (!ext_clk_q || ext_rise) begin
            conv_cnt_q <= conv_cnt_q - 32'd1; // R15
          end
          if (conv_cnt_q <= 32'd1 && (!ext_clk_q || ext_rise)) begin
            conv_state_q <= CONV_IDLE;
            conv_done_q <= 1'b1; // R17
            conv_busy_q <= !single_q;
            if (act_path_q == PATH_AMPLIFIER) begin
              result_q <= mod_data_q[MOD_W-1 -: RES_W];
            end else if (act_gain_q >= GAIN_DIG_MAX) begin
              result_q <= mod_data_q[MOD_W-3 -: RES_W]; // R14
            end else if (act_gain_q == 3'h1) begin
              result_q <= mod_data_q[MOD_W-2 -: RES_W]; // R13
            end else begin
              result_q <= mod_data_q[MOD_W-1 -: RES_W]; // R14
            end
          end
        end
        default: conv_state_q <= CONV_IDLE;
      endcase
    end
  end

  // analog control outputs, driven from the settings in force
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {pos_input_sel_q, neg_input_sel_q} <= '0;
      reference_zero_en_q <= 1'b0;
      {excitation_current_source_zero_route_q, excitation_current_source_one_route_q} <= '0;
      excitation_level_q <= '0;
      bias_voltage_source_route_q <= '0;
      {wire_sink_en_q, wire_source_en_q} <= '0;
      {input_buffer_en_q, programmable_gain_amplifier_en_q} <= '0;
      {amp_gain_q, external_clock_select_q} <= '0;
    end else begin
      pos_input_sel_q <= onehot11(act_pos_q); // R1
      neg_input_sel_q <= onehot11(act_neg_q); // R2
      reference_zero_en_q <= ref0_sel_q; // R3
      excitation_current_source_zero_route_q <= cur0_on_q ? 10'(onehot11(cur0_pin_q)) : '0; // R4
      excitation_current_source_one_route_q <= cur1_on_q ? 10'(onehot11(cur1_pin_q)) : '0; // R4
      excitation_level_q <= level_q; // R6
      bias_voltage_source_route_q <= bias_q; // R5
      wire_sink_en_q <= sink_q; // R7
      wire_source_en_q <= source_q; // R7
      input_buffer_en_q <= (act_path_q == PATH_BUFFERED); // R9 R10 R11
      programmable_gain_amplifier_en_q <= (act_path_q == PATH_AMPLIFIER); // R9 R10 R11
      amp_gain_q <= act_gain_q; // R12
      external_clock_select_q <= ext_clk_q;
    end
  end

  // read channel: one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFS_MUX: s_axi_rdata <= {19'h0, ref0_sel_q, 4'h0, mux_neg_q, mux_pos_q};
          OFS_EXCITE: s_axi_rdata <= {8'h0, source_q, sink_q, bias_q, level_q, cur1_on_q,
                                      cur0_on_q, cur1_pin_q, cur0_pin_q};
          OFS_PATH: s_axi_rdata <= {27'h0, gain_q, path_q};
          OFS_CONV: s_axi_rdata <= {29'h0, fir_q, single_q, ext_clk_q};
          OFS_RESULT: s_axi_rdata <= {8'h0, result_q};
          OFS_STATUS: s_axi_rdata <= {26'h0, act_gain_q, conv_state_q == CONV_RUN,
                                      conv_busy_q, 1'b0};
          OFS_MOD_DATA: s_axi_rdata <= mod_data_q;
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : input_path_control
`default_nettype wire

// ==== logic/input_path_pkg.sv ====
// constants and types shared by the converter input path control block
package input_path_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_MUX = 8'h00;
  localparam logic [7:0] OFS_EXCITE = 8'h04;
  localparam logic [7:0] OFS_PATH = 8'h08;
  localparam logic [7:0] OFS_CONV = 8'h0C;
  localparam logic [7:0] OFS_RESULT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MOD_DATA = 8'h18;
  // mux codes: 0..9 analog inputs, 10 = supply rail (positive) / ground rail (negative)
  localparam logic [3:0] MUX_LAST_PIN = 4'h9;
  localparam logic [3:0] MUX_RAIL = 4'hA;
  localparam logic [3:0] BIAS_LAST_PIN = 4'h7;
  localparam logic [3:0] IDAC_LAST_PIN = 4'h9;
  localparam logic [2:0] GAIN_DIG_MAX = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int MOD_W = 32;
  localparam int RES_W = 24;
  // conversion timing at 250 MHz
  localparam int CLK_MHZ = 250;
  localparam int CONT_RATE_SPS = 1920;
  localparam int SINGLE_RATE_SPS = 480;
  localparam int FIR_SETTLE_MS = 16;
  localparam int CONT_CYCLES = (CLK_MHZ * 1000000 + CONT_RATE_SPS - 1) / CONT_RATE_SPS;
  localparam int SINGLE_CYCLES = (CLK_MHZ * 1000000 + SINGLE_RATE_SPS - 1) / SINGLE_RATE_SPS;
  localparam int FIR_CYCLES = FIR_SETTLE_MS * CLK_MHZ * 1000;
  // with the external clock, lengths are counted in pin periods at the nominal pin frequency
  localparam int EXT_CLK_HZ = 2457600;
  localparam int CONT_EDGES = EXT_CLK_HZ / CONT_RATE_SPS;
  localparam int SINGLE_EDGES = EXT_CLK_HZ / SINGLE_RATE_SPS;
  localparam int FIR_EDGES = (FIR_SETTLE_MS * EXT_CLK_HZ + 999) / 1000;
  typedef enum logic [1:0] {
    PATH_BYPASS = 2'b00,
    PATH_BUFFERED = 2'b01,
    PATH_AMPLIFIER = 2'b10
  } path_type;
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01
  } conv_state_type;
endpackage : input_path_pkg

// ==== tb/input_path_control_props.sv ====
// concurrent checks on the input path control ports
`timescale 1ns/1ps
`default_nettype none
module input_path_control_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [10:0] pos_input_sel_q,
  input wire logic [10:0] neg_input_sel_q,
  input wire logic input_buffer_en_q,
  input wire logic programmable_gain_amplifier_en_q,
  input wire logic [2:0] amp_gain_q,
  input wire logic conv_busy_q,
  input wire logic conv_done_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a restart reloads settings just after done, so only long quiet spans count
  sequence mid_conv;
    (conv_busy_q && !conv_done_q)[*8];
  endsequence
  AST_POS_ONEHOT: assert property ($onehot0(pos_input_sel_q))
    else $error("positive select not one-hot");
  AST_NEG_ONEHOT: assert property ($onehot0(neg_input_sel_q))
    else $error("negative select not one-hot");
  AST_PATH: assert property (!(input_buffer_en_q && programmable_gain_amplifier_en_q))
    else $error("buffers and amplifier both on");
  AST_DONE_PULSE: assert property (conv_done_q |=> !conv_done_q)
    else $error("done longer than one cycle");
  AST_HELD: assert property (mid_conv |-> $stable(pos_input_sel_q) && $stable(amp_gain_q))
    else $error("setting changed mid conversion");
  AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("read answer late");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
endmodule : input_path_control_props
bind input_path_control input_path_control_props u_props (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .pos_input_sel_q, .neg_input_sel_q, .input_buffer_en_q,
  .programmable_gain_amplifier_en_q, .amp_gain_q, .conv_busy_q, .conv_done_q
);
`default_nettype wire

// ==== tb/ext_clock_source.sv ====
// conversion clock source on the external clock pin
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source (
  input wire logic run,
  output logic clk_out
);
  // odd offset keeps pin edges off the block clock edges
  initial begin
    clk_out = 1'b0;
    #3.3;
    forever begin
      #16;
      clk_out = run ? ~clk_out : 1'b0;
    end
  end
endmodule : ext_clock_source
`default_nettype wire

// ==== tb/test_adc_input_path_control.sv ====
// self-checking bench for the converter input path control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_input_path_control
  import input_path_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ext_run;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, bias_voltage_source_route_q;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr_q, rd_d, mod_d;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
  logic [10:0] pos_input_sel_q, neg_input_sel_q;
  logic [9:0] excitation_current_source_zero_route_q, excitation_current_source_one_route_q;
  logic [3:0] excitation_level_q;
  logic [2:0] amp_gain_q;
  logic general_pin_zero_clock_in, reference_zero_en_q, wire_sink_en_q, wire_source_en_q;
  logic input_buffer_en_q, programmable_gain_amplifier_en_q, external_clock_select_q;
  logic conv_busy_q, conv_done_q;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  input_path_control dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .general_pin_zero_clock_in,
    .pos_input_sel_q, .neg_input_sel_q, .reference_zero_en_q,
    .excitation_current_source_zero_route_q, .excitation_current_source_one_route_q,
    .excitation_level_q, .bias_voltage_source_route_q, .wire_sink_en_q, .wire_source_en_q,
    .input_buffer_en_q, .programmable_gain_amplifier_en_q, .amp_gain_q,
    .external_clock_select_q, .conv_busy_q, .conv_done_q
  );
  ext_clock_source pin_src (.run(ext_run), .clk_out(general_pin_zero_clock_in));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // three pin-clock conversions of about 10240 cycles each, plus margin
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [23:0] dig_cut(input logic [31:0] m, input logic [1:0] p,
                                          input logic [2:0] g);
    if (p == PATH_AMPLIFIER || g == 3'h0) return m[31:8];
    if (g == 3'h1) return m[30:7];
    return m[29:6];
  endfunction : dig_cut
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wr_r = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
  endtask : rd
  initial begin
    logic [1:0] p, p_old;
    logic [2:0] g, g_old;
    logic [3:0] pc, nc, ic;
    logic [10:0] pos_old;
    logic rf;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ext_run} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    lfsr_q = 32'h0001_6fc5;
    p = 2'h0;
    g = 3'h0;
    pos_old = 11'h000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    ext_run <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(neg_input_sel_q, 11'h400, "neg rail");
    rd(8'h1c);
    chk(32'(rd_r), 32'(RESP_SLVERR), "unmapped read resp");
    chk(rd_d, 32'h0000_0000, "unmapped read data");
    wr(8'h1c, 32'h0000_0001);
    chk(32'(wr_r), 32'(RESP_SLVERR), "unmapped write resp");
    // continuous mode: settings written mid-run land at the next start
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      p_old = p;
      g_old = g;
      p = 2'(i % 3);
      g = lfsr_q[10:8];
      pc = (i == 0) ? MUX_RAIL : 4'(lfsr_q[3:0] % 11);
      nc = (i == 1) ? MUX_RAIL : 4'(lfsr_q[7:4] % 11);
      ic = 4'(lfsr_q[15:12] % 10);
      rf = lfsr_q[24];
      mod_d = ~lfsr_q;
      wr(OFS_MUX, {19'h0_0000, rf, 4'h0, nc, pc});
      wr(OFS_EXCITE, {8'h00, lfsr_q[23:10], 2'b01, ic, ic});
      wr(OFS_PATH, {27'h000_0000, g, p});
      wr(OFS_MOD_DATA, mod_d);
      chk(32'(wr_r), 32'(RESP_OKAY), "write resp");
      rd(OFS_MUX);
      chk(rd_d[7:0], {nc, pc}, "mux readback");
      if (i == 0) begin
        wr(OFS_CONV, 32'h0000_0009);
      end else begin
        chk(pos_input_sel_q, pos_old, "held");
        rd(OFS_STATUS);
        chk(rd_d, {26'h000_0000, g_old, 2'b11, 1'b0}, "status");
        chk(conv_busy_q, 1'b1, "busy");
        do @(posedge aclk); while (!conv_done_q);
      end
      repeat (4) @(posedge aclk);
      if (i > 0) begin
        rd(OFS_RESULT);
        chk(rd_d, {8'h00, dig_cut(mod_d, p_old, g_old)}, "result");
      end
      pos_old = 11'h001 << pc;
      chk(pos_input_sel_q, pos_old, "pos");
      chk(neg_input_sel_q, 11'h001 << nc, "neg");
      chk(excitation_current_source_zero_route_q, 10'h001 << ic, "route0");
      chk(excitation_current_source_one_route_q, 10'h000, "route1");
      chk({reference_zero_en_q, excitation_level_q, bias_voltage_source_route_q,
           wire_source_en_q, wire_sink_en_q}, {rf, lfsr_q[13:10], lfsr_q[21:14],
           lfsr_q[23:22]}, "excite");
      chk({programmable_gain_amplifier_en_q, input_buffer_en_q}, p, "path");
      if (p == PATH_AMPLIFIER) chk(amp_gain_q, g, "gain");
      chk(external_clock_select_q, 1'b1, "ext clock");
    end
    // refused codes leave the registers as they were
    wr(OFS_MUX, 32'h0000_00ff);
    wr(OFS_PATH, 32'h0000_0003);
    rd(OFS_MUX);
    chk(rd_d[7:0], {nc, pc}, "mux refused");
    rd(OFS_PATH);
    chk(rd_d[1:0], p, "path refused");
    final_report();
  end
endmodule : test_adc_input_path_control
`default_nettype wire
